// [verilog/msc_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

// Register offsets
`define MSC_ADDR_SUPPLY_MON      6'h0c
`define MSC_ADDR_SHUNT_AMP       6'h0d

// Reset values
`define MSC_RST_SUPPLY_MON       8'h14
`define MSC_RST_SHUNT_AMP        8'h01

// Supply monitor control field positions
`define MSC_UV_RESP_BIT          7
`define MSC_OV_RESP_HI           6
`define MSC_OV_RESP_LO           5
`define MSC_OV_FILT_HI           4
`define MSC_OV_FILT_LO           3
`define MSC_OV_THR_BIT           2
`define MSC_PUMP_RESP_BIT        1
`define MSC_PUMP_THR_BIT         0

// Shunt amplifier control field positions
`define MSC_SH_EN_BIT            7
`define MSC_BLK_SRC_BIT          6
`define MSC_BLK_DUR_HI           5
`define MSC_BLK_DUR_LO           3
`define MSC_REF_DIV_BIT          2
`define MSC_GAIN_HI              1
`define MSC_GAIN_LO              0

// Clock rate and overvoltage filter times
`define MSC_CLK_MHZ              50
`define MSC_OV_FILT0_US          1
`define MSC_OV_FILT1_US          2
`define MSC_OV_FILT2_US          4
`define MSC_OV_FILT3_US          8
`define MSC_OV_FILT0_CYC         (`MSC_OV_FILT0_US * `MSC_CLK_MHZ)
`define MSC_OV_FILT1_CYC         (`MSC_OV_FILT1_US * `MSC_CLK_MHZ)
`define MSC_OV_FILT2_CYC         (`MSC_OV_FILT2_US * `MSC_CLK_MHZ)
`define MSC_OV_FILT3_CYC         (`MSC_OV_FILT3_US * `MSC_CLK_MHZ)
`define MSC_OV_CNT_W             9

// Gain figures in V/V
`define MSC_GAIN0_VV             7'h0a
`define MSC_GAIN1_VV             7'h14
`define MSC_GAIN2_VV             7'h28
`define MSC_GAIN3_VV             7'h50

`endif

// [verilog/msc_pkg.sv]
// Types shared by the monitor and shunt amplifier configuration block
package msc_pkg;

  typedef enum logic [1:0] {
    MSC_OV_LATCHED,
    MSC_OV_AUTO,
    MSC_OV_WARN_ONLY,
    MSC_OV_DISABLED
  } msc_ov_resp_t;

  typedef struct packed {
    logic         supply_undervolt_response;
    msc_ov_resp_t supply_overvolt_response;
    logic [1:0]   supply_overvolt_filter_time;
    logic         supply_overvolt_threshold_sel;
    logic         pump_undervolt_response;
    logic         pump_undervolt_threshold_sel;
  } msc_mon_cfg_t;

  typedef struct packed {
    logic       amp_sample_hold_enable;
    logic       amp_blanking_source;
    logic [2:0] amp_blanking_duration;
    logic       amp_reference_divider;
    logic [1:0] amp_gain_select;
  } msc_amp_cfg_t;

  typedef struct packed {
    logic supply_undervolt;
    logic supply_overvolt;
    logic pump_undervolt;
  } msc_cond_t;

endpackage

// [verilog/msc_fault_cell.sv]
// One monitor fault flag with latched or automatic recovery
module msc_fault_cell (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_cond,
  input  wire logic i_enable,
  input  wire logic i_auto,
  input  wire logic i_clear,
  output logic      o_flag
);

  // Set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (!i_enable) begin
      o_flag <= 1'b0;
    end else if (i_cond) begin
      o_flag <= 1'b1;
    end else if (i_auto) begin
      o_flag <= 1'b0;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

endmodule

// [verilog/msc_top.sv]
// Monitor and shunt amplifier configuration registers with fault flags
`include "msc_map.svh"

module msc_top #(
  parameter int ADDR_W = 6
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_reg_wr,
  input  wire logic [ADDR_W-1:0]     i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  output logic      [7:0]            o_reg_rdata,
  input  wire msc_pkg::msc_cond_t    i_cond,
  input  wire logic                  i_fault_clear,
  output msc_pkg::msc_mon_cfg_t      o_mon_cfg,
  output msc_pkg::msc_amp_cfg_t      o_amp_cfg,
  output logic      [3:0]            o_amp_blanking_eighths,
  output logic      [6:0]            o_amp_gain_vv,
  output logic                       o_supply_undervolt_fault,
  output logic                       o_supply_overvolt_fault,
  output logic                       o_supply_overvolt_warning,
  output logic                       o_pump_undervolt_fault
);

  localparam logic [ADDR_W-1:0] MON_ADDR = ADDR_W'(`MSC_ADDR_SUPPLY_MON);
  localparam logic [ADDR_W-1:0] AMP_ADDR = ADDR_W'(`MSC_ADDR_SHUNT_AMP);
  localparam logic [8:0] FILT0 = 9'(`MSC_OV_FILT0_CYC);
  localparam logic [8:0] FILT1 = 9'(`MSC_OV_FILT1_CYC);
  localparam logic [8:0] FILT2 = 9'(`MSC_OV_FILT2_CYC);
  localparam logic [8:0] FILT3 = 9'(`MSC_OV_FILT3_CYC);
  localparam logic [7:0] MON_RST = `MSC_RST_SUPPLY_MON;
  localparam logic [7:0] AMP_RST = `MSC_RST_SHUNT_AMP;

  logic [7:0]                   supply_monitor_control;
  logic [7:0]                   shunt_amplifier_control;
  logic [7:0]                   next_rdata;
  logic [3:0]                   next_blanking;
  logic [6:0]                   next_gain;
  logic [`MSC_OV_CNT_W-1:0]     ov_count;
  logic [`MSC_OV_CNT_W-1:0]     ov_limit;
  logic                         ov_filtered;
  logic                         ov_fault_en;
  logic                         ov_warn_en;
  msc_pkg::msc_ov_resp_t        ov_resp;
  logic [7:0]                   next_mon;
  logic [7:0]                   next_amp;
  logic                         cfg_uv_resp;
  msc_pkg::msc_ov_resp_t        cfg_ov_resp;
  logic [1:0]                   cfg_ov_filt;
  logic                         cfg_ov_thr;
  logic                         cfg_pump_resp;
  logic                         cfg_pump_thr;
  logic                         cfg_sh_en;
  logic                         cfg_blk_src;
  logic [2:0]                   cfg_blk_dur;
  logic                         cfg_ref_div;
  logic [1:0]                   cfg_gain;

  // Monitor control register; writes take effect on the next edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      supply_monitor_control <= `MSC_RST_SUPPLY_MON;
    end else if (i_reg_wr && i_reg_addr == MON_ADDR) begin
      supply_monitor_control <= i_reg_wdata;
    end
  end

  // Amplifier control register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shunt_amplifier_control <= `MSC_RST_SHUNT_AMP;
    end else if (i_reg_wr && i_reg_addr == AMP_ADDR) begin
      shunt_amplifier_control <= i_reg_wdata;
    end
  end

  // Read mux; unmapped addresses read zero, reads change nothing
  always_comb begin
    next_rdata = 8'h00;
    if (i_reg_addr == MON_ADDR) begin
      next_rdata = supply_monitor_control;
    end else if (i_reg_addr == AMP_ADDR) begin
      next_rdata = shunt_amplifier_control;
    end
  end

  // Registered read data, one cycle behind the address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= next_rdata;
    end
  end

  // Supply undervoltage response; one flop per field keeps resets apart
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_uv_resp <= MON_RST[`MSC_UV_RESP_BIT];
    end else begin
      cfg_uv_resp <= next_mon[`MSC_UV_RESP_BIT];
    end
  end

  // Supply overvoltage response mode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ov_resp <= msc_pkg::msc_ov_resp_t'(
        MON_RST[`MSC_OV_RESP_HI:`MSC_OV_RESP_LO]);
    end else begin
      cfg_ov_resp <= msc_pkg::msc_ov_resp_t'(
        next_mon[`MSC_OV_RESP_HI:`MSC_OV_RESP_LO]);
    end
  end

  // Overvoltage filter time code
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ov_filt <= MON_RST[`MSC_OV_FILT_HI:`MSC_OV_FILT_LO];
    end else begin
      cfg_ov_filt <= next_mon[`MSC_OV_FILT_HI:`MSC_OV_FILT_LO];
    end
  end

  // Overvoltage threshold select for the analog comparator
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ov_thr <= MON_RST[`MSC_OV_THR_BIT];
    end else begin
      cfg_ov_thr <= next_mon[`MSC_OV_THR_BIT];
    end
  end

  // Charge pump undervoltage response
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_pump_resp <= MON_RST[`MSC_PUMP_RESP_BIT];
    end else begin
      cfg_pump_resp <= next_mon[`MSC_PUMP_RESP_BIT];
    end
  end

  // Charge pump undervoltage threshold select
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_pump_thr <= MON_RST[`MSC_PUMP_THR_BIT];
    end else begin
      cfg_pump_thr <= next_mon[`MSC_PUMP_THR_BIT];
    end
  end

  // Monitor bundle; same bit order as the register
  assign o_mon_cfg = '{cfg_uv_resp, cfg_ov_resp, cfg_ov_filt, cfg_ov_thr,
                       cfg_pump_resp, cfg_pump_thr};

  // Value each control register holds after this edge, so settings follow
  // a write in the same cycle as the register itself
  always_comb begin
    next_mon = supply_monitor_control;
    next_amp = shunt_amplifier_control;
    if (i_reg_wr && i_reg_addr == MON_ADDR) begin
      next_mon = i_reg_wdata;
    end
    if (i_reg_wr && i_reg_addr == AMP_ADDR) begin
      next_amp = i_reg_wdata;
    end
  end

  // Amplifier sample-and-hold enable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_sh_en <= AMP_RST[`MSC_SH_EN_BIT];
    end else begin
      cfg_sh_en <= next_amp[`MSC_SH_EN_BIT];
    end
  end

  // Half-bridge whose switching starts blanking
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_blk_src <= AMP_RST[`MSC_BLK_SRC_BIT];
    end else begin
      cfg_blk_src <= next_amp[`MSC_BLK_SRC_BIT];
    end
  end

  // Blanking duration code
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_blk_dur <= AMP_RST[`MSC_BLK_DUR_HI:`MSC_BLK_DUR_LO];
    end else begin
      cfg_blk_dur <= next_amp[`MSC_BLK_DUR_HI:`MSC_BLK_DUR_LO];
    end
  end

  // Reference divider select
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ref_div <= AMP_RST[`MSC_REF_DIV_BIT];
    end else begin
      cfg_ref_div <= next_amp[`MSC_REF_DIV_BIT];
    end
  end

  // Gain code
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_gain <= AMP_RST[`MSC_GAIN_HI:`MSC_GAIN_LO];
    end else begin
      cfg_gain <= next_amp[`MSC_GAIN_HI:`MSC_GAIN_LO];
    end
  end

  // Amplifier bundle; same bit order as the register
  assign o_amp_cfg = '{cfg_sh_en, cfg_blk_src, cfg_blk_dur, cfg_ref_div,
                       cfg_gain};

  // Blanking in eighths of gate drive time: code 0 is off, else code+1
  always_comb begin
    next_blanking = 4'h0;
    if (next_amp[`MSC_BLK_DUR_HI:`MSC_BLK_DUR_LO] != 3'h0) begin
      next_blanking =
        {1'b0, next_amp[`MSC_BLK_DUR_HI:`MSC_BLK_DUR_LO]} + 4'h1;
    end
  end

  // Gain code to V/V figure
  always_comb begin
    unique case (next_amp[`MSC_GAIN_HI:`MSC_GAIN_LO])
      2'h0: next_gain = `MSC_GAIN0_VV;
      2'h1: next_gain = `MSC_GAIN1_VV;
      2'h2: next_gain = `MSC_GAIN2_VV;
      2'h3: next_gain = `MSC_GAIN3_VV;
    endcase
  end

  // Decoded amplifier figures, registered so outputs come from flops
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_amp_blanking_eighths <= 4'h0;
      o_amp_gain_vv          <= `MSC_GAIN1_VV;
    end else begin
      o_amp_blanking_eighths <= next_blanking;
      o_amp_gain_vv          <= next_gain;
    end
  end

  // Filter length from the live register field
  always_comb begin
    unique case (supply_monitor_control[`MSC_OV_FILT_HI:`MSC_OV_FILT_LO])
      2'h0: ov_limit = FILT0;
      2'h1: ov_limit = FILT1;
      2'h2: ov_limit = FILT2;
      2'h3: ov_limit = FILT3;
    endcase
  end

  // Overvoltage must persist for the whole filter time; any drop restarts
  // the count, so short glitches never reach the fault flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ov_count    <= '0;
      ov_filtered <= 1'b0;
    end else if (!i_cond.supply_overvolt) begin
      ov_count    <= '0;
      ov_filtered <= 1'b0;
    end else if (ov_count >= ov_limit - 9'h001) begin
      ov_filtered <= 1'b1;
    end else begin
      ov_count <= ov_count + 9'h001;
    end
  end

  // Response mode selects fault or warning path for overvoltage
  assign ov_resp = msc_pkg::msc_ov_resp_t'(
    supply_monitor_control[`MSC_OV_RESP_HI:`MSC_OV_RESP_LO]);
  assign ov_fault_en = (ov_resp == msc_pkg::MSC_OV_LATCHED) ||
                       (ov_resp == msc_pkg::MSC_OV_AUTO);
  assign ov_warn_en  = (ov_resp == msc_pkg::MSC_OV_WARN_ONLY);

  // Supply undervoltage flag
  msc_fault_cell u_supply_uv (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_cond   (i_cond.supply_undervolt),
    .i_enable (1'b1),
    .i_auto   (supply_monitor_control[`MSC_UV_RESP_BIT]),
    .i_clear  (i_fault_clear),
    .o_flag   (o_supply_undervolt_fault)
  );

  // Supply overvoltage fault, latched or auto, off otherwise
  msc_fault_cell u_supply_ov (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_cond   (ov_filtered),
    .i_enable (ov_fault_en),
    .i_auto   (ov_resp == msc_pkg::MSC_OV_AUTO),
    .i_clear  (i_fault_clear),
    .o_flag   (o_supply_overvolt_fault)
  );

  // Warning only: follows the filtered condition, never shuts down
  msc_fault_cell u_supply_ov_warn (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_cond   (ov_filtered),
    .i_enable (ov_warn_en),
    .i_auto   (1'b1),
    .i_clear  (i_fault_clear),
    .o_flag   (o_supply_overvolt_warning)
  );

  // Charge pump undervoltage flag
  msc_fault_cell u_pump_uv (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_cond   (i_cond.pump_undervolt),
    .i_enable (1'b1),
    .i_auto   (supply_monitor_control[`MSC_PUMP_RESP_BIT]),
    .i_clear  (i_fault_clear),
    .o_flag   (o_pump_undervolt_fault)
  );

endmodule

// [testbench/msc_assertions.sv]
// Port-level checks for the monitor and amplifier config block
module msc_assertions #(
  parameter int ADDR_W = 6
) (
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire logic                  i_reg_wr,
  input wire logic [ADDR_W-1:0]     i_reg_addr,
  input wire logic [7:0]            i_reg_wdata,
  input wire logic [7:0]            o_reg_rdata,
  input wire logic                  i_fault_clear,
  input wire msc_pkg::msc_cond_t    i_cond,
  input wire msc_pkg::msc_mon_cfg_t o_mon_cfg,
  input wire msc_pkg::msc_amp_cfg_t o_amp_cfg,
  input wire logic [3:0]            o_amp_blanking_eighths,
  input wire logic [6:0]            o_amp_gain_vv,
  input wire logic                  o_supply_undervolt_fault,
  input wire logic                  o_supply_overvolt_fault,
  input wire logic                  o_supply_overvolt_warning,
  input wire logic                  o_pump_undervolt_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic sel_mon;
  logic sel_amp;
  // Address decode shared by the checks
  assign sel_mon = i_reg_addr == 6'h0c;
  assign sel_amp = i_reg_addr == 6'h0d;

  property p_wr_mon;
    i_reg_wr && sel_mon |=> o_mon_cfg == $past(i_reg_wdata);
  endproperty
  a_wr_mon: assert property (p_wr_mon)
    else $error("monitor write lost");
  property p_wr_amp;
    i_reg_wr && sel_amp |=> o_amp_cfg == $past(i_reg_wdata);
  endproperty
  a_wr_amp: assert property (p_wr_amp)
    else $error("amplifier write lost");
  property p_hold;
    !(i_reg_wr && (sel_mon || sel_amp)) |=>
      $stable(o_mon_cfg) && $stable(o_amp_cfg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("config changed without write");
  property p_rst_val;
    $fell(i_rst) |-> o_mon_cfg == 8'h14 && o_amp_cfg == 8'h01;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("reset value wrong");
  property p_rd;
    sel_mon |=> o_reg_rdata == $past(o_mon_cfg);
  endproperty
  a_rd: assert property (p_rd)
    else $error("monitor readback wrong");
  property p_rd_none;
    !sel_mon && !sel_amp |=> o_reg_rdata == 8'h00;
  endproperty
  a_rd_none: assert property (p_rd_none)
    else $error("unmapped read not zero");
  property p_gain;
    o_amp_gain_vv == (7'h0a << o_amp_cfg.amp_gain_select);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain figure wrong");
  property p_blank;
    o_amp_blanking_eighths == ((o_amp_cfg.amp_blanking_duration == 3'h0) ?
      4'h0 : {1'b0, o_amp_cfg.amp_blanking_duration} + 4'h1);
  endproperty
  a_blank: assert property (p_blank)
    else $error("blanking eighths wrong");
  property p_ov_off;
    (o_mon_cfg.supply_overvolt_response == msc_pkg::MSC_OV_DISABLED)[*2]
      |-> !o_supply_overvolt_fault && !o_supply_overvolt_warning;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("disabled monitor flagged");
  property p_uv_latch;
    o_supply_undervolt_fault && !o_mon_cfg.supply_undervolt_response &&
      !i_fault_clear |=> o_supply_undervolt_fault;
  endproperty
  a_uv_latch: assert property (p_uv_latch)
    else $error("latched fault dropped");
  property p_pump_set;
    i_cond.pump_undervolt |=> o_pump_undervolt_fault;
  endproperty
  a_pump_set: assert property (p_pump_set)
    else $error("pump fault not raised");
  property p_pump_latch;
    o_pump_undervolt_fault && !o_mon_cfg.pump_undervolt_response &&
      !i_fault_clear |=> o_pump_undervolt_fault;
  endproperty
  a_pump_latch: assert property (p_pump_latch)
    else $error("latched pump fault dropped");
endmodule

// [testbench/msc_host_model.sv]
// Controller model driving the parallel register port
module msc_host_model (
  input  wire logic i_clk,
  output logic      o_wr,
  output logic [5:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus from time zero
  initial begin
    o_wr = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  // One-cycle strobe; data inverted after so stale values never match
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge i_clk);
    o_addr = a;
  endtask
endmodule

// [testbench/monitor_and_shunt_amp_config_tb.sv]
// Self-checking bench for the monitor and amplifier config block
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
  end \
end
module monitor_and_shunt_amp_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_clk = 1'b0;
  logic                  i_rst = 1'b1;
  logic                  reg_wr;
  logic [5:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic [7:0]            reg_rdata;
  msc_pkg::msc_cond_t    cond = '0;
  logic                  fault_clear = 1'b0;
  msc_pkg::msc_mon_cfg_t mon_cfg;
  msc_pkg::msc_amp_cfg_t amp_cfg;
  logic [3:0]            blank_8ths;
  logic [6:0]            gain_vv;
  logic                  uv_flt;
  logic                  ov_flt;
  logic                  ov_warn;
  logic                  pump_flt;
  int                    error_cnt = 0;
  int                    n_checks = 0;
  // 50 MHz clock
  always #10 i_clk = ~i_clk;
  msc_host_model i_msc_host_model (.i_clk(i_clk), .o_wr(reg_wr),
    .o_addr(reg_addr), .o_wdata(reg_wdata));
  msc_top i_msc_top (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(reg_wr),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .i_cond(cond), .i_fault_clear(fault_clear),
    .o_mon_cfg(mon_cfg), .o_amp_cfg(amp_cfg),
    .o_amp_blanking_eighths(blank_8ths), .o_amp_gain_vv(gain_vv),
    .o_supply_undervolt_fault(uv_flt), .o_supply_overvolt_fault(ov_flt),
    .o_supply_overvolt_warning(ov_warn), .o_pump_undervolt_fault(pump_flt));
  task automatic final_report;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Readback one cycle after the address is presented
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    i_msc_host_model.rd(a);
    @(negedge i_clk);
    `CHK(reg_rdata, e)
  endtask
  // Reset values, also applied again at the end of the run
  task automatic check_reset;
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    `CHK(mon_cfg, 8'h14)
    `CHK(amp_cfg, 8'h01)
    `CHK(gain_vv, 7'h14)
    `CHK(blank_8ths, 4'h0)
    rd_chk(6'h0c, 8'h14);
    rd_chk(6'h0d, 8'h01);
  endtask
  // Every field both ways, every blanking and gain code, one stray write
  task automatic check_regs;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[0], ~i[0], i[2:0], i[1], i[1:0]};
      i_msc_host_model.wr(6'h0d, d);
      `CHK(amp_cfg, d)
      `CHK(blank_8ths, (i == 0) ? 4'h0 : 4'(i + 1))
      `CHK(gain_vv, 7'h0a << i[1:0])
      i_msc_host_model.wr(6'h0c, ~d);
      `CHK(mon_cfg, ~d)
      rd_chk(6'h0d, d);
    end
    i_msc_host_model.wr(6'h0e, 8'h5a);
    `CHK({mon_cfg, amp_cfg}, {~d, d})
    rd_chk(6'h0e, 8'h00);
  endtask
  // Undervoltage faults latched, then with automatic recovery
  task automatic check_uv;
    for (int m = 0; m < 2; m++) begin
      i_msc_host_model.wr(6'h0c, {m[0], 5'h02, m[0], 1'b0});
      cond = 3'b101;
      @(negedge i_clk);
      `CHK({uv_flt, pump_flt}, 2'b11)
      cond = 3'b000;
      repeat (2) @(negedge i_clk);
      `CHK({uv_flt, pump_flt}, {2{~m[0]}})
      fault_clear = 1'b1;
      @(negedge i_clk);
      fault_clear = 1'b0;
      `CHK({uv_flt, pump_flt}, 2'b00)
    end
  endtask
  // Overvoltage filter boundary and response for one mode and code
  task automatic ov_run(input logic [7:0] v, input int n, input logic f,
                        input logic w, input logic h);
    i_msc_host_model.wr(6'h0c, v);
    cond = 3'b010;
    repeat (n) @(negedge i_clk);
    `CHK({ov_flt, ov_warn}, 2'b00)
    @(negedge i_clk);
    `CHK({ov_flt, ov_warn}, {f, w})
    cond = 3'b000;
    repeat (3) @(negedge i_clk);
    `CHK({ov_flt, ov_warn}, {h, 1'b0})
    fault_clear = 1'b1;
    @(negedge i_clk);
    fault_clear = 1'b0;
    `CHK({ov_flt, ov_warn}, 2'b00)
  endtask
  initial begin
    check_reset;
    check_regs;
    check_uv;
    ov_run(8'h04, 50, 1'b1, 1'b0, 1'b1);
    ov_run(8'h2c, 100, 1'b1, 1'b0, 1'b0);
    ov_run(8'h54, 200, 1'b0, 1'b1, 1'b0);
    ov_run(8'h7c, 400, 1'b0, 1'b0, 1'b0);
    check_reset;
    final_report;
  end
endmodule
bind msc_top msc_assertions #(.ADDR_W(ADDR_W)) i_msc_assertions (
  .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_fault_clear(i_fault_clear),
  .i_cond(i_cond),
  .o_mon_cfg(o_mon_cfg), .o_amp_cfg(o_amp_cfg),
  .o_amp_blanking_eighths(o_amp_blanking_eighths),
  .o_amp_gain_vv(o_amp_gain_vv),
  .o_supply_undervolt_fault(o_supply_undervolt_fault),
  .o_supply_overvolt_fault(o_supply_overvolt_fault),
  .o_supply_overvolt_warning(o_supply_overvolt_warning),
  .o_pump_undervolt_fault(o_pump_undervolt_fault));
